/* hw/irq_en_pkg.sv */
// Summary of operation
// - clock-stable enable bit gates the clocks-stable event onto the irq output
// - suspend-entry enable bit gates the suspend-entry event onto the irq output
// - dma-done enable bit gates the dma completion event onto the irq output
// - frame-start enable bit gates every start-of-frame event onto the irq output
// - mask bit n applies to the done map of descriptor n
// - isochronous any-done mask, 32-bit rw, reset zero, selects or-condition members
// - periodic any-done mask, 32-bit rw, reset zero, selects or-condition members
// - async any-done mask, 32-bit rw, reset zero, selects or-condition members
// - isochronous all-done mask, 32-bit rw, reset zero, all-zero means no and-condition
// - periodic all-done mask, 32-bit rw, reset zero, selects and-condition members
// - async all-done mask, 32-bit rw, reset zero, selects and-condition members
// - per-list completion enables on bits 9, 8, 7 gate list completion irq
`default_nettype none
package irq_en_pkg;
  localparam int          DW             = 32;
  localparam int          AW             = 12;
  localparam logic [11:0] OFS_IRQ_ENABLE = 12'h314;
  localparam logic [11:0] OFS_ISO_ANY    = 12'h318;
  localparam logic [11:0] OFS_PER_ANY    = 12'h31C;
  localparam logic [11:0] OFS_ASY_ANY    = 12'h320;
  localparam logic [11:0] OFS_ISO_ALL    = 12'h324;
  localparam logic [11:0] OFS_PER_ALL    = 12'h328;
  localparam logic [11:0] OFS_ASY_ALL    = 12'h32C;
  localparam int          BIT_FRAME      = 1;
  localparam int          BIT_DMA        = 3;
  localparam int          BIT_SUSP       = 5;
  localparam int          BIT_CLK        = 6;
  localparam int          BIT_PER        = 7;
  localparam int          BIT_ASY        = 8;
  localparam int          BIT_ISO        = 9;
  // writable enable bits; reserved positions read back zero
  localparam logic [31:0] EN_WMASK       = 32'h0000_03EA;
  localparam logic [31:0] RST_VAL        = 32'h0000_0000;
  localparam int          NREG           = 7;
  localparam logic [2:0]  IDX_EN         = 3'h0;
endpackage
`default_nettype wire

/* hw/list_done_eval.sv */
`default_nettype none
module list_done_eval
  import irq_en_pkg::*;
(
  input  wire logic                      i_clk,
  input  wire logic                      i_rst,
  input  wire logic [irq_en_pkg::DW-1:0] i_done,
  input  wire logic [irq_en_pkg::DW-1:0] i_any_sel,
  input  wire logic [irq_en_pkg::DW-1:0] i_all_sel,
  output logic                           o_hit
);
  import irq_en_pkg::*;
  typedef struct packed {
    logic hit;
  } st_t;
  st_t st_r;
  st_t st_nxt;
  // bit n of each mask looks at descriptor n only
  // or/and combination
  always_comb begin
    st_nxt.hit = ((i_done & i_any_sel) != '0) ||
                 ((i_all_sel != '0) && ((i_done & i_all_sel) == i_all_sel));
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign o_hit = st_r.hit;
  and_empty_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_all_sel == '0 && (i_done & i_any_sel) == '0) |=> !o_hit)
    else $error("empty and-mask raised a hit");
endmodule
`default_nettype wire

/* hw/usb_host_irq_enable_and_masks.sv */
`default_nettype none
module usb_host_irq_enable_and_masks
  import irq_en_pkg::*;
(
  input  wire logic                   I_CLK,
  input  wire logic                   I_RST,
  input  wire logic [irq_en_pkg::AW-1:0] I_ADDR,
  input  wire logic                   I_WR,
  input  wire logic                   I_RD,
  input  wire logic [irq_en_pkg::DW-1:0] I_WDATA,
  output logic      [irq_en_pkg::DW-1:0] O_RDATA,
  input  wire logic                   I_CLK_STABLE_EV,
  input  wire logic                   I_SUSPEND_EV,
  input  wire logic                   I_DMA_DONE_EV,
  input  wire logic                   I_FRAME_START_EV,
  input  wire logic [irq_en_pkg::DW-1:0] I_ISO_DONE,
  input  wire logic [irq_en_pkg::DW-1:0] I_PER_DONE,
  input  wire logic [irq_en_pkg::DW-1:0] I_ASY_DONE,
  output logic      [irq_en_pkg::DW-1:0] O_IRQ_ENABLE,
  output logic                        O_IRQ
);
  import irq_en_pkg::*;
  typedef struct packed {
    logic [NREG-1:0][DW-1:0] regs;
    logic [DW-1:0]           rdata;
    logic                    irq;
  } st_t;
  st_t st_r;
  st_t st_nxt;
  logic [2:0] hit;
  // coined names for the stored words, all views of st_r
  logic [DW-1:0] irq_enable;
  logic [DW-1:0] isochronous_any_done_mask;
  logic [DW-1:0] periodic_any_done_mask;
  logic [DW-1:0] async_any_done_mask;
  logic [DW-1:0] isochronous_all_done_mask;
  logic [DW-1:0] periodic_all_done_mask;
  logic [DW-1:0] async_all_done_mask;

  // map a byte address onto a register index; 7 means unmapped
  function automatic logic [2:0] decode(input logic [AW-1:0] a);
    if (a == OFS_IRQ_ENABLE) begin
      decode = 3'h0;
    end else if (a == OFS_ISO_ANY) begin
      decode = 3'h1;
    end else if (a == OFS_PER_ANY) begin
      decode = 3'h2;
    end else if (a == OFS_ASY_ANY) begin
      decode = 3'h3;
    end else if (a == OFS_ISO_ALL) begin
      decode = 3'h4;
    end else if (a == OFS_PER_ALL) begin
      decode = 3'h5;
    end else if (a == OFS_ASY_ALL) begin
      decode = 3'h6;
    end else begin
      decode = 3'h7;
    end
  endfunction

  // one evaluator per list: index 0 iso, 1 periodic, 2 async
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_list
      list_done_eval u_eval (
        .i_clk     (I_CLK),
        .i_rst     (I_RST),
        .i_done    (g == 0 ? I_ISO_DONE : (g == 1 ? I_PER_DONE : I_ASY_DONE)),
        .i_any_sel (st_r.regs[1 + g]),
        .i_all_sel (st_r.regs[4 + g]),
        .o_hit     (hit[g])
      );
    end
  endgenerate

  // register writes, registered readback and irq combine
  always_comb begin
    logic [2:0]    idx;
    logic [DW-1:0] en;
    idx    = decode(I_ADDR);
    en     = st_r.regs[IDX_EN];
    st_nxt = st_r;
    if (I_WR && idx != 3'h7) begin
      st_nxt.regs[idx] = (idx == IDX_EN) ? (I_WDATA & EN_WMASK) : I_WDATA;
    end
    // unmapped reads return zero
    st_nxt.rdata = (I_RD && idx != 3'h7) ? st_r.regs[idx] : RST_VAL;
    st_nxt.irq = (en[BIT_CLK] && I_CLK_STABLE_EV) ||
                 (en[BIT_SUSP] && I_SUSPEND_EV) ||
                 (en[BIT_DMA] && I_DMA_DONE_EV) ||
                 (en[BIT_FRAME] && I_FRAME_START_EV) ||
                 (en[BIT_ISO] && hit[0]) ||
                 (en[BIT_PER] && hit[1]) ||
                 (en[BIT_ASY] && hit[2]);
  end

  // all state reset to zero
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign O_RDATA      = st_r.rdata;
  assign O_IRQ        = st_r.irq;
  assign O_IRQ_ENABLE = irq_enable;

  // coined register names, read by the checks below
  assign irq_enable                = st_r.regs[IDX_EN];
  assign isochronous_any_done_mask = st_r.regs[1];
  assign periodic_any_done_mask    = st_r.regs[2];
  assign async_any_done_mask       = st_r.regs[3];
  assign isochronous_all_done_mask = st_r.regs[4];
  assign periodic_all_done_mask    = st_r.regs[5];
  assign async_all_done_mask       = st_r.regs[6];

  clk_gate_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (I_CLK_STABLE_EV && O_IRQ_ENABLE[BIT_CLK]) |=> O_IRQ)
    else $error("clock-stable event did not raise irq");
  susp_gate_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (I_SUSPEND_EV && O_IRQ_ENABLE[BIT_SUSP]) |=> O_IRQ)
    else $error("suspend event did not raise irq");
  dma_gate_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (I_DMA_DONE_EV && O_IRQ_ENABLE[BIT_DMA]) |=> O_IRQ)
    else $error("dma done did not raise irq");
  frame_gate_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (I_FRAME_START_EV && O_IRQ_ENABLE[BIT_FRAME]) |=> O_IRQ)
    else $error("frame start did not raise irq");
  all_off_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (O_IRQ_ENABLE == '0 && !I_WR) |=> !O_IRQ)
    else $error("irq with every enable off");
  rsvd_zero_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (O_IRQ_ENABLE & ~EN_WMASK) == '0)
    else $error("reserved enable bit set");

  // readback of each mask right after its write; the read must see the new word
  // iso any-done readback
  mask_wr_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (I_WR && I_ADDR == OFS_ISO_ANY) ##1 (I_RD && I_ADDR == OFS_ISO_ANY && !I_WR)
      |=> O_RDATA == $past(I_WDATA, 2))
    else $error("mask readback mismatch");
  per_any_rd_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (I_WR && I_ADDR == OFS_PER_ANY) ##1 (I_RD && I_ADDR == OFS_PER_ANY && !I_WR)
      |=> O_RDATA == $past(I_WDATA, 2))
    else $error("periodic any-done mask readback mismatch");
  asy_any_rd_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (I_WR && I_ADDR == OFS_ASY_ANY) ##1 (I_RD && I_ADDR == OFS_ASY_ANY && !I_WR)
      |=> O_RDATA == $past(I_WDATA, 2))
    else $error("async any-done mask readback mismatch");
  iso_all_rd_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (I_WR && I_ADDR == OFS_ISO_ALL) ##1 (I_RD && I_ADDR == OFS_ISO_ALL && !I_WR)
      |=> O_RDATA == $past(I_WDATA, 2))
    else $error("iso all-done mask readback mismatch");
  per_all_rd_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (I_WR && I_ADDR == OFS_PER_ALL) ##1 (I_RD && I_ADDR == OFS_PER_ALL && !I_WR)
      |=> O_RDATA == $past(I_WDATA, 2))
    else $error("periodic all-done mask readback mismatch");
  asy_all_rd_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (I_WR && I_ADDR == OFS_ASY_ALL) ##1 (I_RD && I_ADDR == OFS_ASY_ALL && !I_WR)
      |=> O_RDATA == $past(I_WDATA, 2))
    else $error("async all-done mask readback mismatch");

  // or-condition: hit one edge after the done map, irq one edge later
  // iso or-condition
  iso_list_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    ((I_ISO_DONE & isochronous_any_done_mask) != '0 && O_IRQ_ENABLE[BIT_ISO] && !I_WR) |-> ##2 O_IRQ)
    else $error("iso or-condition did not raise irq");
  per_list_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    ((I_PER_DONE & periodic_any_done_mask) != '0 && O_IRQ_ENABLE[BIT_PER] && !I_WR) |-> ##2 O_IRQ)
    else $error("periodic or-condition did not raise irq");
  asy_list_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    ((I_ASY_DONE & async_any_done_mask) != '0 && O_IRQ_ENABLE[BIT_ASY] && !I_WR) |-> ##2 O_IRQ)
    else $error("async or-condition did not raise irq");

  // and-condition: every selected descriptor done, empty mask never counts
  // iso and-condition
  iso_and_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (isochronous_all_done_mask != '0 && (I_ISO_DONE & isochronous_all_done_mask) == isochronous_all_done_mask
      && O_IRQ_ENABLE[BIT_ISO] && !I_WR) |-> ##2 O_IRQ)
    else $error("iso and-condition did not raise irq");
  per_and_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (periodic_all_done_mask != '0 && (I_PER_DONE & periodic_all_done_mask) == periodic_all_done_mask
      && O_IRQ_ENABLE[BIT_PER] && !I_WR) |-> ##2 O_IRQ)
    else $error("periodic and-condition did not raise irq");
  asy_and_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (async_all_done_mask != '0 && (I_ASY_DONE & async_all_done_mask) == async_all_done_mask
      && O_IRQ_ENABLE[BIT_ASY] && !I_WR) |-> ##2 O_IRQ)
    else $error("async and-condition did not raise irq");

  // one list enable alone: irq follows that list's hit and nothing else
  // iso enable alone
  iso_only_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (O_IRQ_ENABLE == (32'h1 << BIT_ISO)) |=> (O_IRQ == $past(hit[0])))
    else $error("iso enable alone let another cause through");
  per_only_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (O_IRQ_ENABLE == (32'h1 << BIT_PER)) |=> (O_IRQ == $past(hit[1])))
    else $error("periodic enable alone let another cause through");
  asy_only_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (O_IRQ_ENABLE == (32'h1 << BIT_ASY)) |=> (O_IRQ == $past(hit[2])))
    else $error("async enable alone let another cause through");

  rst_clear_a: assert property (@(posedge I_CLK) I_RST |=> (st_r.regs == '0 && O_RDATA == '0 && !O_IRQ))
    else $error("state not cleared by reset");
  // unmapped reads answer zero so software never sees stale data
  unmapped_rd_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (I_RD && decode(I_ADDR) == 3'h7) |=> O_RDATA == '0)
    else $error("unmapped read returned data");

  // main scenarios reached
  cov_iso_c: cover property (@(posedge I_CLK) O_IRQ_ENABLE[BIT_ISO] && hit[0]);
  cov_per_c: cover property (@(posedge I_CLK) O_IRQ_ENABLE[BIT_PER] && hit[1]);
  cov_asy_c: cover property (@(posedge I_CLK) O_IRQ_ENABLE[BIT_ASY] && hit[2]);
  cov_and_c: cover property (@(posedge I_CLK) isochronous_all_done_mask != '0 && hit[0]);
  cov_frame_c: cover property (@(posedge I_CLK) I_FRAME_START_EV && O_IRQ_ENABLE[BIT_FRAME]);
endmodule
`default_nettype wire

/* bench/testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import irq_en_pkg::*;
  logic          clk, rst, wr, rd, irq;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata, en_q;
  logic [DW-1:0] done [3];
  logic [3:0]    ev;
  int            n_mismatch, comparisons;
  // list order: isochronous, periodic, async
  int            en_bit [3] = '{BIT_ISO, BIT_PER, BIT_ASY};
  int            ev_bit [4] = '{BIT_FRAME, BIT_DMA, BIT_SUSP, BIT_CLK};

  usb_host_irq_enable_and_masks usb_host_irq_enable_and_masks_inst (
    .I_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WR(wr), .I_RD(rd), .I_WDATA(wdata), .O_RDATA(rdata),
    .I_FRAME_START_EV(ev[0]), .I_DMA_DONE_EV(ev[1]), .I_SUSPEND_EV(ev[2]), .I_CLK_STABLE_EV(ev[3]),
    .I_ISO_DONE(done[0]), .I_PER_DONE(done[1]), .I_ASY_DONE(done[2]), .O_IRQ_ENABLE(en_q), .O_IRQ(irq));

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(string what, logic [DW-1:0] seen, logic [DW-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // strobe dropped with an idle edge so back-to-back calls never retoggle it
  task automatic wr_reg(logic [AW-1:0] a, logic [DW-1:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk) #1;
    wr = 1'b0;
    @(posedge clk) #1;
  endtask

  task automatic rd_chk(logic [AW-1:0] a, logic [DW-1:0] exp);
    addr = a;
    rd = 1'b1;
    @(posedge clk) #1;
    check("rdata", rdata, exp);
    rd = 1'b0;
    @(posedge clk) #1;
  endtask

  // write then read the same word on the very next edge
  task automatic wr_rd_chk(logic [AW-1:0] a, logic [DW-1:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk) #1;
    wr = 1'b0;
    rd = 1'b1;
    @(posedge clk) #1;
    check("readback", rdata, d);
    rd = 1'b0;
    @(posedge clk) #1;
  endtask

  // distinct test word per register index
  function automatic logic [DW-1:0] pat(int i);
    return {8'hA5, 8'(i), 16'h3C5A};
  endfunction

  // descriptor path needs two edges; the third gives margin
  task automatic irq_chk(logic exp);
    repeat (3) @(posedge clk);
    #1;
    check("irq", DW'(irq), DW'(exp));
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog against a hung run
  initial begin
    #50us;
    n_mismatch++;
    conclude();
  end

  // main sequence
  initial begin
    {wr, rd, addr, wdata, ev} = '0;
    rst = 1'b1;
    done = '{default: '0};
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd_chk(OFS_IRQ_ENABLE + AW'(4 * i), RST_VAL);
    end
    for (int i = 1; i < 7; i++) wr_reg(OFS_IRQ_ENABLE + AW'(4 * i), pat(i));
    for (int i = 1; i < 7; i++) begin
      rd_chk(OFS_IRQ_ENABLE + AW'(4 * i), pat(i));
    end
    for (int i = 1; i < 7; i++) begin
      wr_rd_chk(OFS_IRQ_ENABLE + AW'(4 * i), ~pat(i));
    end
    // reset in mid-run must clear every stored mask
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd_chk(OFS_IRQ_ENABLE + AW'(4 * i), RST_VAL);
    end
    wr_reg(12'h330, 32'hFFFF_FFFF);
    rd_chk(12'h330, 32'h0);
    for (int i = 1; i < 7; i++) wr_reg(OFS_IRQ_ENABLE + AW'(4 * i), 32'h0);
    // low reserved bits written as zero; the upper unused bits still get ones
    wr_reg(OFS_IRQ_ENABLE, 32'hFFFF_FFEA);
    rd_chk(OFS_IRQ_ENABLE, EN_WMASK);
    check("enable", en_q, EN_WMASK);
    $display("test registers done");
    // each event with only its own enable on, then with all others on
    for (int k = 0; k < 4; k++) begin
      wr_reg(OFS_IRQ_ENABLE, DW'(1) << ev_bit[k]);
      ev = 4'h1 << k;
      irq_chk(1'b1);
      ev = 4'h0;
      irq_chk(1'b0);
      wr_reg(OFS_IRQ_ENABLE, EN_WMASK & ~(DW'(1) << ev_bit[k]));
      ev = 4'h1 << k;
      irq_chk(1'b0);
      ev = 4'h0;
    end
    $display("test events done");
    // or and and conditions per list
    for (int l = 0; l < 3; l++) begin
      wr_reg(OFS_IRQ_ENABLE, DW'(1) << en_bit[l]);
      wr_reg(OFS_ISO_ANY + AW'(4 * l), 32'h8000_0000);
      done[l] = 32'h4000_0000;
      irq_chk(1'b0);
      done[l] = 32'h8000_0000;
      irq_chk(1'b1);
      wr_reg(OFS_IRQ_ENABLE, EN_WMASK & ~(DW'(1) << en_bit[l]));
      irq_chk(1'b0);
      wr_reg(OFS_ISO_ANY + AW'(4 * l), 32'h0);
      wr_reg(OFS_IRQ_ENABLE, DW'(1) << en_bit[l]);
      done[l] = 32'hFFFF_FFFF;
      irq_chk(1'b0);
      wr_reg(OFS_ISO_ALL + AW'(4 * l), 32'h0000_0011);
      done[l] = 32'h0000_0001;
      irq_chk(1'b0);
      done[l] = 32'h0000_0011;
      irq_chk(1'b1);
      wr_reg(OFS_ISO_ALL + AW'(4 * l), 32'h0);
      done[l] = 32'h0;
    end
    $display("test lists done");
    conclude();
  end
endmodule
`default_nettype wire
